// [hdl/led_regs_map.svh]
// register offsets, field positions and reset values of the led sink register group
`ifndef LED_REGS_MAP_SVH
`define LED_REGS_MAP_SVH

`define OFS_PROTECTION_STATUS 8'h02
`define OFS_DEVICE_IDENTITY   8'h03
`define OFS_SINK_CURRENT      8'h07
`define OFS_CONVERTER_SETUP   8'h08

`define RST_PROTECTION_STATUS 8'h00
`define RST_SINK_CURRENT      8'hff
`define RST_CONVERTER_SETUP   8'h1f

`define BIT_FAULT_SUMMARY     0
`define BIT_THERMAL_TRIP      1
`define BIT_INPUT_OVERCURRENT 2
`define BIT_BACKLIGHT_ON      3
`define BIT_ANY_CHANNEL_DOWN  4
`define BIT_MULTI_CHANNEL_DOWN 5
`define MSK_STATUS_RESERVED   8'hc0

`define BIT_PANEL_TYPE        7
`define PANEL_TYPE_VALUE      1'b1

`define BIT_SHORT_ENABLE      0
`define BIT_FREQ_SELECT       2
`define POS_DRIVE_LO          3
`define POS_DRIVE_HI          4

`define FREQ_FAST_KHZ         11'h4b0
`define FREQ_SLOW_KHZ         11'h258
`define SHORT_THRESHOLD_MV    13'h1d4c

`define CHANNEL_COUNT         6

`endif

// [hdl/led_regs_pkg.sv]
// types shared by the led sink register group
package led_regs_pkg;

  typedef logic [7:0] reg_byte_t;

  typedef enum logic [1:0] {
    DRIVE_QUARTER,
    DRIVE_HALF,
    DRIVE_THREE_QUARTER,
    DRIVE_FULL
  } drive_strength_t;

endpackage : led_regs_pkg

// [hdl/level_sync.sv]
// two flip-flop synchroniser for a group of asynchronous level inputs
`timescale 1ns/1ns
module level_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage is read only by the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : level_sync

// [hdl/led_sink_status_config_regs.sv]
// status, identity, sink current and converter setup registers of the led driver
`timescale 1ns/1ns
`include "led_regs_map.svh"

module led_sink_status_config_regs #(
  parameter logic [3:0] MAKER_CODE = 4'h5,  // value is arbitrary
  parameter logic [2:0] REV_CODE   = 3'h0   // value is arbitrary
) (
  input  wire logic                            clk,
  input  wire logic                            reset,
  input  wire logic [7:0]                      reg_addr,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  input  wire led_regs_pkg::reg_byte_t         reg_wdata,
  output led_regs_pkg::reg_byte_t              reg_rdata,
  output logic                                 reg_hit,
  input  wire logic                            thermal_trip_in,
  input  wire logic                            input_overcurrent_in,
  input  wire logic [`CHANNEL_COUNT-1:0]       channel_down_in,
  input  wire logic                            backlight_on_in,
  input  wire logic                            backlight_switch,
  output led_regs_pkg::reg_byte_t              dc_current_level,
  output led_regs_pkg::drive_strength_t        gate_drive_strength,
  output logic [6:0]                           drive_percent,
  output logic                                 boost_freq_select,
  output logic [10:0]                          switch_freq_khz,
  output logic                                 short_threshold_enable,
  output logic [12:0]                          short_threshold_mv
);
  import led_regs_pkg::*;

  function automatic logic two_or_more(input logic [`CHANNEL_COUNT-1:0] v);
    logic [2:0] cnt;
    cnt = 3'h0;
    for (int i = 0; i < `CHANNEL_COUNT; i++) begin
      cnt = cnt + {2'h0, v[i]};
    end
    return (cnt >= 3'h2);
  endfunction : two_or_more

  function automatic logic [6:0] drive_to_percent(input drive_strength_t d);
    case (d)
      DRIVE_QUARTER:       return 7'h19;
      DRIVE_HALF:          return 7'h32;
      DRIVE_THREE_QUARTER: return 7'h4b;
      DRIVE_FULL:          return 7'h64;
      default:             return 7'h19;
    endcase
  endfunction : drive_to_percent

  logic                      thermal_sync;
  logic                      overcurrent_sync;
  logic                      backlight_sync;
  logic [`CHANNEL_COUNT-1:0] down_sync;
  logic                      any_down;
  logic                      multi_down;
  logic                      fault_cause;
  logic                      fault_reg;
  logic                      fault_next;
  logic                      switch_prev_reg;
  logic                      switch_toggle;
  logic                      clear_by_write;
  logic                      fault_clear;
  reg_byte_t                 status_view;
  reg_byte_t                 identity_view;
  reg_byte_t                 level_reg;
  reg_byte_t                 setup_reg;
  reg_byte_t                 read_mux;
  logic                      addr_known;
  logic                      status_sel;
  logic                      level_sel;
  logic                      setup_sel;

  // detector inputs come from analog circuits on no clock
  level_sync #(.WIDTH(`CHANNEL_COUNT + 3)) detector_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in ({channel_down_in, backlight_on_in, input_overcurrent_in, thermal_trip_in}),
    .sync_out ({down_sync, backlight_sync, overcurrent_sync, thermal_sync})
  );

  assign any_down    = |down_sync;
  assign multi_down  = two_or_more(down_sync);
  // backlight state is deliberately left out of the cause
  assign fault_cause = thermal_sync | overcurrent_sync | any_down | multi_down;

  assign status_sel = (reg_addr == `OFS_PROTECTION_STATUS);
  assign level_sel  = (reg_addr == `OFS_SINK_CURRENT);
  assign setup_sel  = (reg_addr == `OFS_CONVERTER_SETUP);
  assign addr_known = status_sel || level_sel || setup_sel ||
                      (reg_addr == `OFS_DEVICE_IDENTITY);

  // only bit 0 of the status register responds to a write
  assign clear_by_write = reg_wr && status_sel && !reg_wdata[`BIT_FAULT_SUMMARY];
  assign switch_toggle  = backlight_switch ^ switch_prev_reg;
  assign fault_clear    = clear_by_write || switch_toggle;

  // a live cause wins over a clear in the same cycle
  always_comb begin
    if (fault_cause) begin
      fault_next = 1'b1;
    end else if (fault_clear) begin
      fault_next = 1'b0;
    end else begin
      fault_next = fault_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fault_reg <= 1'((`RST_PROTECTION_STATUS >> `BIT_FAULT_SUMMARY) & 8'h01);
    end else begin
      fault_reg <= fault_next;
    end
  end

  // the switch comes from the same clock; no synchroniser needed
  always_ff @(posedge clk) begin
    if (reset) begin
      switch_prev_reg <= 1'b0;
    end else begin
      switch_prev_reg <= backlight_switch;
    end
  end

  always_comb begin
    status_view                          = 8'h00;
    status_view[`BIT_FAULT_SUMMARY]      = fault_reg;
    status_view[`BIT_THERMAL_TRIP]       = thermal_sync;
    status_view[`BIT_INPUT_OVERCURRENT]  = overcurrent_sync;
    status_view[`BIT_BACKLIGHT_ON]       = backlight_sync;
    status_view[`BIT_ANY_CHANNEL_DOWN]   = any_down;
    status_view[`BIT_MULTI_CHANNEL_DOWN] = multi_down;
  end

  assign identity_view = {`PANEL_TYPE_VALUE, MAKER_CODE, REV_CODE};

  always_ff @(posedge clk) begin
    if (reset) begin
      level_reg <= `RST_SINK_CURRENT;
    end else if (reg_wr && level_sel) begin
      level_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      setup_reg <= `RST_CONVERTER_SETUP;
    end else if (reg_wr && setup_sel) begin
      setup_reg <= reg_wdata;
    end
  end

  always_comb begin
    case (1'b1)
      status_sel:                          read_mux = status_view;
      (reg_addr == `OFS_DEVICE_IDENTITY):  read_mux = identity_view;
      level_sel:                           read_mux = level_reg;
      setup_sel:                           read_mux = setup_reg;
      default:                             read_mux = 8'h00;
    endcase
  end

  // read data is captured at the edge that samples the read strobe, visible one cycle later
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      reg_hit   <= 1'b0;
    end else if (reg_rd) begin
      reg_rdata <= read_mux;
      reg_hit   <= addr_known;
    end
  end

  // the level drives the sink current linearly; new value acts at once
  assign dc_current_level       = level_reg;
  assign gate_drive_strength    = drive_strength_t'(setup_reg[`POS_DRIVE_HI:`POS_DRIVE_LO]);
  assign drive_percent          = drive_to_percent(gate_drive_strength);
  assign boost_freq_select      = setup_reg[`BIT_FREQ_SELECT];
  assign switch_freq_khz        = boost_freq_select ? `FREQ_SLOW_KHZ : `FREQ_FAST_KHZ;
  assign short_threshold_enable = setup_reg[`BIT_SHORT_ENABLE];
  // the host keeps string mismatch under the threshold before enabling
  assign short_threshold_mv     = short_threshold_enable ? `SHORT_THRESHOLD_MV : 13'h0000;

  // ---- assertions ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence status_read_s;
    reg_rd && status_sel;
  endsequence

  sequence clear_request_s;
    fault_clear && !fault_cause;
  endsequence

  sequence detectors_quiet_s;
    !thermal_trip_in && !input_overcurrent_in && (channel_down_in == '0);
  endsequence

  reserved_bits_zero_a: assert property (status_read_s |=> reg_rdata[7:6] == 2'b00)
    else $error("reserved status bits read nonzero");

  status_write_kept_a: assert property (
    reg_wr && status_sel && reg_wdata[`BIT_FAULT_SUMMARY] && fault_reg |=> fault_reg)
    else $error("writing 1 to status altered the fault summary");

  backlight_flag_live_a: assert property (
    $stable(backlight_on_in)[*3] |-> status_view[`BIT_BACKLIGHT_ON] == backlight_on_in)
    else $error("backlight flag does not follow the backlight state");

  fault_sets_a: assert property (fault_cause |=> fault_reg)
    else $error("fault summary not set by a live cause");

  any_down_flag_a: assert property (
    status_view[`BIT_ANY_CHANNEL_DOWN] == (down_sync != '0))
    else $error("any channel down flag wrong");

  multi_down_flag_a: assert property (
    status_view[`BIT_MULTI_CHANNEL_DOWN] == ($countones(down_sync) >= 2))
    else $error("multi channel down flag wrong");

  fault_holds_a: assert property (fault_reg && !fault_clear |=> fault_reg)
    else $error("fault summary dropped without a clear");

  fault_clears_a: assert property (clear_request_s |=> !fault_reg)
    else $error("fault summary not cleared");

  fault_reasserts_a: assert property (
    fault_clear && fault_cause |=> fault_reg ##1 (fault_reg || !$past(fault_cause)))
    else $error("fault summary lost a cause present at clear");

  backlight_no_fault_a: assert property (
    detectors_quiet_s ##1 detectors_quiet_s ##1
    (!fault_reg && !fault_cause ##0 detectors_quiet_s) |=> !fault_reg)
    else $error("fault summary set without a fault cause");

  status_after_reset_a: assert property (
    @(posedge clk) $fell(reset) |-> status_view == `RST_PROTECTION_STATUS)
    else $error("status not zero after reset");

  overcurrent_live_a: assert property (
    $stable(input_overcurrent_in)[*3] |->
    status_view[`BIT_INPUT_OVERCURRENT] == input_overcurrent_in)
    else $error("overcurrent flag wrong");

  identity_fixed_a: assert property (
    reg_rd && reg_addr == `OFS_DEVICE_IDENTITY |=>
    reg_rdata == {`PANEL_TYPE_VALUE, MAKER_CODE, REV_CODE})
    else $error("identity read wrong");

  level_write_a: assert property (
    reg_wr && level_sel |=> dc_current_level == $past(reg_wdata))
    else $error("sink level not updated by write");

  drive_code_a: assert property (
    drive_percent == 7'(25 * (int'(setup_reg[`POS_DRIVE_HI:`POS_DRIVE_LO]) + 1)))
    else $error("drive percent does not match field");

  freq_code_a: assert property (
    reg_wr && setup_sel |=>
    switch_freq_khz == ($past(reg_wdata[`BIT_FREQ_SELECT]) ? 11'd600 : 11'd1200))
    else $error("switching frequency mismatch");

  setup_reset_a: assert property (
    @(posedge clk) $fell(reset) |-> setup_reg == 8'h1f && dc_current_level == 8'hff)
    else $error("setup or level reset value wrong");

  thermal_sync_a: assert property (
    $rose(thermal_trip_in) ##1 thermal_trip_in[*2] |=> fault_reg)
    else $error("thermal trip not seen after synchroniser");

endmodule : led_sink_status_config_regs

// [verif/led_host_model.sv]
// host model issuing single byte reads and writes on the register port
`timescale 1ns/1ns
module led_host_model (
  input  wire logic                    clk,
  output logic [7:0]                   reg_addr,
  output logic                         reg_wr,
  output logic                         reg_rd,
  output led_regs_pkg::reg_byte_t      reg_wdata,
  input  wire led_regs_pkg::reg_byte_t reg_rdata,
  input  wire logic                    reg_hit
);
  import led_regs_pkg::*;

  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // released lines carry the inverse so a stale sample cannot pass
  task automatic wr_byte(input logic [7:0] a, input reg_byte_t d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr_byte

  task automatic rd_byte(input logic [7:0] a, output reg_byte_t d, output logic h);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    h = reg_hit;
  endtask : rd_byte
endmodule : led_host_model

// [verif/led_sink_status_config_regs_tb_top.sv]
// self-checking bench of the led sink register group
`timescale 1ns/1ns
`include "led_regs_map.svh"
module led_sink_status_config_regs_tb_top;
  import led_regs_pkg::*;
  localparam logic [3:0] MAKER = 4'ha;  // value is arbitrary
  localparam logic [2:0] REV = 3'h2;    // value is arbitrary
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  reg_byte_t reg_wdata;
  reg_byte_t reg_rdata;
  logic reg_hit;
  logic [8:0] pins = 9'h000;
  logic sw = 1'b0;
  reg_byte_t level;
  drive_strength_t drive;
  logic [6:0] pct;
  logic fsel;
  logic [10:0] khz;
  logic sen;
  logic [12:0] mv;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;

  always #10 clk = ~clk;

  led_host_model i_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit));

  led_sink_status_config_regs #(.MAKER_CODE(MAKER), .REV_CODE(REV)) i_dut (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .thermal_trip_in(pins[0]), .input_overcurrent_in(pins[1]),
    .channel_down_in(pins[`CHANNEL_COUNT+1:2]), .backlight_on_in(pins[8]),
    .backlight_switch(sw), .dc_current_level(level), .gate_drive_strength(drive),
    .drive_percent(pct), .boost_freq_select(fsel), .switch_freq_khz(khz),
    .short_threshold_enable(sen), .short_threshold_mv(mv));

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : check

  task automatic rd_chk(input logic [7:0] a, input reg_byte_t e, input logic eh);
    reg_byte_t d;
    logic h;
    i_host.rd_byte(a, d, h);
    check($sformatf("rdata %h", a), {8'h00, e}, {8'h00, d});
    check($sformatf("hit %h", a), {15'h0, eh}, {15'h0, h});
  endtask : rd_chk

  // detector pins change at the falling edge, then settle through the synchroniser
  task automatic set_pins(input logic [8:0] p);
    @(negedge clk);
    pins = p;
    repeat (4) @(negedge clk);
  endtask : set_pins

  task automatic t_reset;
    rd_chk(`OFS_PROTECTION_STATUS, 8'h00, 1'b1);
    rd_chk(`OFS_DEVICE_IDENTITY, {1'b1, MAKER, REV}, 1'b1);
    rd_chk(`OFS_SINK_CURRENT, 8'hff, 1'b1);
    rd_chk(`OFS_CONVERTER_SETUP, 8'h1f, 1'b1);
    check("pct", 16'd100, {9'h0, pct});
    check("khz", 16'd600, {5'h0, khz});
    check("mv", 16'd7500, {3'h0, mv});
  endtask : t_reset

  task automatic t_level;
    reg_byte_t v [3] = '{8'h00, 8'h80, 8'h01};
    foreach (v[i]) begin
      i_host.wr_byte(`OFS_SINK_CURRENT, v[i]);
      check("level", {8'h00, v[i]}, {8'h00, level});
      rd_chk(`OFS_SINK_CURRENT, v[i], 1'b1);
    end
    i_host.wr_byte(`OFS_DEVICE_IDENTITY, 8'h00);
    rd_chk(`OFS_DEVICE_IDENTITY, {1'b1, MAKER, REV}, 1'b1);
    i_host.wr_byte(8'h05, 8'h5a);
    rd_chk(8'h05, 8'h00, 1'b0);
  endtask : t_level

  task automatic t_setup;
    reg_byte_t v;
    logic [1:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 2'(i);
      v = {2'b10, 1'(i / 4), c, 1'(i / 4), ~c[1], c[0]};
      // short detection only armed with string mismatch below the threshold
      i_host.wr_byte(`OFS_CONVERTER_SETUP, v);
      rd_chk(`OFS_CONVERTER_SETUP, v, 1'b1);
      check("drive", {14'h0, c}, {14'h0, drive});
      check("pct", 16'(25 * (i % 4 + 1)), {9'h0, pct});
      check("fsel", {15'h0, v[2]}, {15'h0, fsel});
      check("khz", v[2] ? 16'd600 : 16'd1200, {5'h0, khz});
      check("sen", {15'h0, c[0]}, {15'h0, sen});
      check("mv", c[0] ? 16'd7500 : 16'd0, {3'h0, mv});
    end
  endtask : t_setup

  task automatic t_live;
    logic [8:0] p [6] = '{9'h001, 9'h002, 9'h004, 9'h014, 9'h0fc, 9'h100};
    reg_byte_t e;
    foreach (p[i]) begin
      set_pins(p[i]);
      e = {2'b00, $countones(p[i][7:2]) > 1, |p[i][7:2], p[i][8], p[i][1:0], 1'b0};
      e[0] = |e[5:1] & ~p[i][8];
      rd_chk(`OFS_PROTECTION_STATUS, e, 1'b1);
      set_pins(9'h000);
      rd_chk(`OFS_PROTECTION_STATUS, {7'h0, e[0]}, 1'b1);
      i_host.wr_byte(`OFS_PROTECTION_STATUS, 8'h00);
      rd_chk(`OFS_PROTECTION_STATUS, 8'h00, 1'b1);
    end
  endtask : t_live

  task automatic t_clear;
    set_pins(9'h001);
    i_host.wr_byte(`OFS_PROTECTION_STATUS, 8'h00);
    rd_chk(`OFS_PROTECTION_STATUS, 8'h03, 1'b1);
    set_pins(9'h000);
    sw = 1'b1;
    repeat (2) @(negedge clk);
    rd_chk(`OFS_PROTECTION_STATUS, 8'h00, 1'b1);
    set_pins(9'h002);
    set_pins(9'h000);
    // a written 1 must neither clear the held summary nor show in reserved bits
    i_host.wr_byte(`OFS_PROTECTION_STATUS, 8'hff);
    rd_chk(`OFS_PROTECTION_STATUS, 8'h01, 1'b1);
    sw = 1'b0;
    repeat (2) @(negedge clk);
    rd_chk(`OFS_PROTECTION_STATUS, 8'h00, 1'b1);
  endtask : t_clear

  initial begin
    repeat (8) @(negedge clk);
    reset = 1'b0;
    t_reset();
    t_level();
    t_setup();
    t_live();
    t_clear();
    test_done();
  end
endmodule : led_sink_status_config_regs_tb_top
